//--- sesa_pkg.sv
// Purpose: constants and types for the serial memory slave access engine
// Assumes: 125 MHz core clock, two-wire bus clock used as second clock domain
// Notes: register bit positions and lock codes live here; the slave and bench also pack the read value by literal position
package sesa_pkg;

  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int ADDR_W = 14;
  localparam int MEM_BYTES = 16384;
  localparam int PAGE_BYTES = 32;
  localparam logic [15:0] REG_ADDR = 16'hffff;
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // ************************************************************
  // protection control register layout
  // ************************************************************
  localparam int PCR_ARM_BIT = 7;
  localparam int PCR_LOCK_HI_BIT = 4;
  localparam int PCR_LOCK_LO_BIT = 3;
  localparam int PCR_RLATCH_BIT = 2;
  localparam int PCR_WLATCH_BIT = 1;
  localparam logic [7:0] PCR_ZERO_MASK = 8'h61;
  localparam logic [7:0] CMD_SET_WLATCH = 8'h02;
  localparam logic [7:0] CMD_CLR_WLATCH = 8'h00;
  localparam logic [7:0] CMD_SET_RLATCH = 8'h06;
  localparam logic [1:0] LOCK_NONE = 2'h0;
  localparam logic [1:0] LOCK_QUARTER = 2'h1;
  localparam logic [1:0] LOCK_HALF = 2'h2;
  localparam logic [1:0] LOCK_FULL = 2'h3;
  localparam logic [ADDR_W-1:0] LOCK_QUARTER_BASE = 14'h3000;
  localparam logic [ADDR_W-1:0] LOCK_HALF_BASE = 14'h2000;

  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam logic [5:0] SYNC_RESET = 6'h30;
  localparam int CLK_MHZ = 125;
  localparam int T_WC_US = 5000;
  localparam int WC_CYCLES = T_WC_US * CLK_MHZ;
  localparam int BUSY_CNT_W = 20;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_DEVADDR = 7'h02,
    ST_ADDRHI  = 7'h04,
    ST_ADDRLO  = 7'h08,
    ST_WDATA   = 7'h10,
    ST_RDATA   = 7'h20,
    ST_IGNORE  = 7'h40
  } sesa_state_e;

  typedef struct packed {
    logic sample;
    logic tog;
  } sesa_link_s;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] sync3;
    logic [5:0] filt;
    logic tog1;
    logic tog2;
    logic tog3;
    logic togF;
    sesa_state_e state;
    logic [3:0] bitCnt;
    logic [7:0] rxSh;
    logic [7:0] txSh;
    logic ackPend;
    logic sdaOe;
    logic sdaOut;
    logic [ADDR_W-1:0] addr;
    logic [7:0] addrHi;
    logic regSel;
    logic pending;
    logic regGot;
    logic [7:0] regData;
    logic [PAGE_BYTES-1:0][7:0] pageBuf;
    logic [PAGE_BYTES-1:0] mask;
    logic [8:0] wPage;
    logic busy;
    logic [BUSY_CNT_W-1:0] busyCnt;
    logic hwProtectArm;
    logic [1:0] lockBits;
    logic regWriteLatch;
    logic writeLatch;
  } sesa_core_s;

endpackage : sesa_pkg

//--- sesa_slave.sv
// Purpose: two-wire slave access engine of a 16K x 8 nonvolatile memory
// Assumes: bus pins are asynchronous to clk; scl also clocks the bit sampler
// Notes: internal write time is a parameter so simulation can shorten it
`timescale 1ns/1ps
`default_nettype none

// Function
// - write: slave address, high then low word address; ack low byte, await data
// - each data byte acknowledged; stop ends load and starts internal write
// - while internal write runs, ignore bus, no acknowledge, data line released
// - page writes up to 32 bytes: first byte plus thirty-one more
// - after each written byte, increment byte in page, wrap within page
// - bytes beyond 32 overwrite earlier loaded data at wrapped location
// - address byte not acknowledged while busy, acknowledged once finished
// - counter holds last address plus one; read address sends that byte
// - read ends on stop or no master acknowledge; device stops sending
// - stop after address bytes loads counter, sends nothing, waits for start
// - master ack fetches next byte across array, wrapping to 0000h
// - protection register changes only via single byte write to FFFFh
// - register write with ones in must-be-zero bits is not performed
// - register write accepts one byte, later bytes get no acknowledge
// - stop after register write starts update or returns to standby
// - read at FFFFh returns register, ends after one byte, counter 0000h
// - layout: 7 arm, 4..3 lock, 2 register latch, 1 write latch
// - write latch one enables nonvolatile writes, zero disables
// - register latch one allows register writes, zero refuses them
// - latches clear at reset; write latch zero ignores array writes, no ack
// - locked region writes acked but no write cycle; codes 01,10,11
// - three steps: 02h, 06h, final value; only third step is nonvolatile
// - pin high and arm set refuse register and locked writes
module sesa_slave
  import sesa_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = sesa_pkg::WC_CYCLES
)
(
  // core clock and reset
  input wire logic clk,
  input wire logic rstn,
  // two-wire bus
  input wire logic sclClk,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // straps and protection
  input wire logic [2:0] devSel,
  input wire logic protectPin,
  // status
  output logic writeBusy
);
  import sesa_pkg::*;

  sesa_core_s q;
  sesa_core_s d;
  sesa_link_s lq;
  sesa_link_s ld;
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] memRd;
  logic memWe;
  logic [ADDR_W-1:0] memA;
  logic [7:0] pcrValue;

  // ************************************************************
  // link domain: sample data on each bus clock rise
  // ************************************************************
  // the toggle marks a fresh sample; the sample stays put a full bus
  // clock period, long enough for the core to pick it up
  always_comb
  begin
    ld = lq;
    ld.sample = sdaIn;
    ld.tog = ~lq.tog;
  end

  always_ff @(posedge sclClk or negedge rstn)
  begin
    if (!rstn)
      lq <= '0;
    else
      lq <= ld;
  end

  // ************************************************************
  // array storage
  // ************************************************************
  assign memRd = mem[q.addr];
  assign memWe = q.busy && (q.busyCnt < BUSY_CNT_W'(PAGE_BYTES)) && q.mask[q.busyCnt[4:0]];
  assign memA = {q.wPage, q.busyCnt[4:0]};

  always_ff @(posedge clk)
  begin
    if (memWe)
      mem[memA] <= q.pageBuf[q.busyCnt[4:0]];
  end

  // unused bits read as zero
  assign pcrValue = {q.hwProtectArm, 2'h0, q.lockBits, q.regWriteLatch, q.writeLatch, 1'h0};

  function automatic logic isLocked(input logic [1:0] lk, input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    if (lk == LOCK_FULL)
      hit = 1'b1;
    else if (lk == LOCK_HALF)
      hit = (a >= LOCK_HALF_BASE);
    else if (lk == LOCK_QUARTER)
      hit = (a >= LOCK_QUARTER_BASE);
    else
      hit = 1'b0;
    return hit;
  endfunction : isLocked

  // ************************************************************
  // core next state
  // ************************************************************
  always_comb
  begin
    logic sclNew;
    logic sdaNew;
    logic startEv;
    logic stopEv;
    logic fallEv;
    logic riseEv;
    logic bitIn;
    logic [7:0] byteIn;
    logic hwLock;
    sclNew = 1'b0;
    sdaNew = 1'b0;
    startEv = 1'b0;
    stopEv = 1'b0;
    fallEv = 1'b0;
    riseEv = 1'b0;
    bitIn = 1'b0;
    byteIn = 8'h00;
    hwLock = 1'b0;
    d = q;

    // three-stage pin capture; a change counts once stages two and three agree
    d.sync1 = {sclClk, sdaIn, protectPin, devSel};
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    for (int i = 0; i < 6; i++)
    begin
      if (q.sync2[i] == q.sync3[i])
        d.filt[i] = q.sync2[i];
    end
    d.tog1 = lq.tog;
    d.tog2 = q.tog1;
    d.tog3 = q.tog2;
    if (q.tog2 == q.tog3)
      d.togF = q.tog2;

    sclNew = (q.sync2[5] == q.sync3[5]) ? q.sync2[5] : q.filt[5];
    sdaNew = (q.sync2[4] == q.sync3[4]) ? q.sync2[4] : q.filt[4];
    startEv = q.filt[5] && sclNew && q.filt[4] && !sdaNew;
    stopEv = q.filt[5] && sclNew && !q.filt[4] && sdaNew;
    fallEv = q.filt[5] && !sclNew;
    riseEv = (q.tog2 == q.tog3) && (q.tog2 != q.togF);
    bitIn = lq.sample;
    byteIn = {q.rxSh[6:0], bitIn};
    hwLock = q.filt[3] && q.hwProtectArm;
    d.sdaOut = 1'b0;

    if (q.busy)
    begin
      // bus fully ignored until the write time has run out
      d.state = ST_IDLE;
      d.sdaOe = 1'b0;
      d.ackPend = 1'b0;
      d.busyCnt = q.busyCnt + 1'b1;
      if (q.busyCnt == BUSY_CNT_W'(WRITE_CYCLES - 1))
      begin
        d.busy = 1'b0;
        d.mask = '0;
      end
    end
    else if (startEv)
    begin
      // a start in mid-load throws the loaded page away
      d.state = ST_DEVADDR;
      d.bitCnt = 4'h0;
      d.ackPend = 1'b0;
      d.sdaOe = 1'b0;
      d.pending = 1'b0;
      d.regGot = 1'b0;
      d.mask = '0;
    end
    else if (stopEv)
    begin
      d.state = ST_IDLE;
      d.sdaOe = 1'b0;
      d.ackPend = 1'b0;
      d.bitCnt = 4'h0;
      if (q.pending && !isLocked(q.lockBits, {q.wPage, 5'h00}))
      begin
        d.busy = 1'b1;
        d.busyCnt = '0;
        d.regWriteLatch = 1'b0;
      end
      d.pending = 1'b0;
      if (q.regGot && ((q.regData & PCR_ZERO_MASK) == 8'h00))
      begin
        if (q.regWriteLatch)
        begin
          // final step: register latch must be clear, write latch set
          if (!q.regData[PCR_RLATCH_BIT] && q.regData[PCR_WLATCH_BIT] && !hwLock)
          begin
            d.hwProtectArm = q.regData[PCR_ARM_BIT];
            d.lockBits = {q.regData[PCR_LOCK_HI_BIT], q.regData[PCR_LOCK_LO_BIT]};
            d.regWriteLatch = 1'b0;
            d.busy = 1'b1;
            d.busyCnt = '0;
          end
        end
        else if (q.regData == CMD_SET_WLATCH)
          d.writeLatch = 1'b1;
        else if (q.regData == CMD_CLR_WLATCH)
          d.writeLatch = 1'b0;
        else if (q.regData == CMD_SET_RLATCH && q.writeLatch)
          d.regWriteLatch = 1'b1;
      end
      d.regGot = 1'b0;
    end
    else
    begin
      // ************************************************************
      // drive on the falling bus clock
      // ************************************************************
      if (fallEv)
      begin
        if (q.state == ST_RDATA && q.bitCnt < BITS_PER_BYTE)
          d.sdaOe = ~q.txSh[7];
        else
          d.sdaOe = (q.bitCnt == BITS_PER_BYTE) && q.ackPend;
      end

      // ************************************************************
      // act on the rising bus clock
      // ************************************************************
      if (riseEv && q.state != ST_IDLE && q.state != ST_IGNORE)
      begin
        if (q.state == ST_RDATA)
        begin
          if (q.bitCnt < BITS_PER_BYTE)
          begin
            d.txSh = {q.txSh[6:0], 1'b0};
            d.bitCnt = q.bitCnt + 1'b1;
          end
          else
          begin
            d.bitCnt = 4'h0;
            if (q.regSel)
            begin
              // register read closes itself after one byte
              d.state = ST_IGNORE;
              d.regSel = 1'b0;
              d.addr = '0;
            end
            else if (!bitIn)
            begin
              d.txSh = memRd;
              d.addr = q.addr + 1'b1;
            end
            else
              d.state = ST_IGNORE;
          end
        end
        else if (q.bitCnt < LAST_BIT)
        begin
          d.rxSh = byteIn;
          d.bitCnt = q.bitCnt + 1'b1;
        end
        else if (q.bitCnt == LAST_BIT)
        begin
          d.rxSh = byteIn;
          d.bitCnt = BITS_PER_BYTE;
          d.ackPend = 1'b0;
          case (q.state)
            ST_DEVADDR:
            begin
              d.ackPend = (byteIn[7:4] == DEV_TYPE) && (byteIn[3:1] == q.filt[2:0]);
            end
            ST_ADDRHI:
            begin
              d.addrHi = byteIn;
              d.ackPend = 1'b1;
            end
            ST_ADDRLO:
            begin
              d.ackPend = 1'b1;
              d.regSel = ({q.addrHi, byteIn} == REG_ADDR);
              d.addr = {q.addrHi[5:0], byteIn};
            end
            ST_WDATA:
            begin
              if (q.regSel)
              begin
                d.ackPend = !q.regGot;
                if (!q.regGot)
                begin
                  d.regData = byteIn;
                  d.regGot = 1'b1;
                end
              end
              else if (q.writeLatch)
              begin
                d.ackPend = 1'b1;
                d.pageBuf[q.addr[4:0]] = byteIn;
                d.mask[q.addr[4:0]] = 1'b1;
                d.wPage = q.addr[13:5];
                d.pending = 1'b1;
                d.addr = {q.addr[13:5], q.addr[4:0] + 5'h01};
              end
              else
                d.ackPend = 1'b0;
            end
            default:
            begin
              d.ackPend = 1'b0;
            end
          endcase
        end
        else
        begin
          // ninth clock: the acknowledge slot closes
          d.bitCnt = 4'h0;
          d.ackPend = 1'b0;
          if (!q.ackPend)
            d.state = ST_IGNORE;
          else
          begin
            case (q.state)
              ST_DEVADDR:
              begin
                if (q.rxSh[0])
                begin
                  d.state = ST_RDATA;
                  if (q.regSel)
                    d.txSh = pcrValue;
                  else
                  begin
                    d.txSh = memRd;
                    d.addr = q.addr + 1'b1;
                  end
                end
                else
                  d.state = ST_ADDRHI;
              end
              ST_ADDRHI:
              begin
                d.state = ST_ADDRLO;
              end
              ST_ADDRLO:
              begin
                d.state = ST_WDATA;
              end
              default:
              begin
                d.state = q.state;
              end
            endcase
          end
        end
      end
    end
  end

  // ************************************************************
  // core registers
  // ************************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
      q.state <= ST_IDLE;
      q.filt <= SYNC_RESET;
      // start at idle bus levels so no false edge follows reset
      q.sync1 <= SYNC_RESET;
      q.sync2 <= SYNC_RESET;
      q.sync3 <= SYNC_RESET;
    end
    else
      q <= d;
  end

  assign sdaOut = q.sdaOut;
  assign sdaOe = q.sdaOe;
  assign writeBusy = q.busy;

endmodule : sesa_slave

`default_nettype wire

//--- sesa_master_bfm.sv
// Purpose: two-wire bus master model for the slave
// Assumes: pulled-up data wire, 160 ns bus clock period
// Notes: bus clock stands high between frames
`timescale 1ns/1ps
`default_nettype none
module sesa_master_bfm (
  // bus
  output var logic sclClk,
  output var logic sdaLow,
  input wire logic sdaIn
);
  initial
  begin
    sclClk = 1'b1;
    sdaLow = 1'b0;
  end
  // ****************
  // frame tasks
  // ****************
  task automatic start();
    sdaLow = 1'b0;
    #40 sclClk = 1'b1;
    #80 sdaLow = 1'b1;
    #80 sclClk = 1'b0;
    #40;
  endtask : start
  task automatic stop();
    sdaLow = 1'b1;
    #40 sclClk = 1'b1;
    #80 sdaLow = 1'b0;
    #80;
  endtask : stop
  // ninth bit: nb high releases the wire, so a read ends there
  task automatic xfer(input logic [7:0] d, input logic nb, output logic [7:0] q,
                      output logic ack);
    logic s;
    for (int i = 8; i >= 0; i--)
    begin
      sdaLow = (i > 0) ? ~d[i - 1] : ~nb;
      #40 sclClk = 1'b1;
      #40 s = sdaIn;
      #40 sclClk = 1'b0;
      #40;
      if (i > 0)
        q = {q[6:0], s};
    end
    ack = ~s;
  endtask : xfer
endmodule : sesa_master_bfm
`default_nettype wire

//--- sesa_slave_chk.sv
// Purpose: pin-level checks of the slave
// Assumes: all pins viewed from the core clock
// Notes: write time comes from the bound parameter
`timescale 1ns/1ps
`default_nettype none
module sesa_slave_chk #(
  parameter int unsigned WRITE_CYCLES = 64
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins
  input wire logic sclClk,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [2:0] devSel,
  input wire logic protectPin,
  input wire logic writeBusy
);
  logic [19:0] busyLen_q;
  logic [19:0] busyLen_d;
  always_comb
    busyLen_d = writeBusy ? busyLen_q + 20'h1 : 20'h0;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      busyLen_q <= 20'h0;
    else
      busyLen_q <= busyLen_d;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ****************
  // steps and checks
  // ****************
  // stop: wire high with clock high, low a few cycles before
  sequence sStop;
    sclClk && sdaIn && !$past(sdaIn, 9);
  endsequence
  sequence sHeld;
    sdaOe [*8];
  endsequence
  a_busy_quiet: assert property (writeBusy |-> !sdaOe)
    else $error("data driven while busy");
  a_drive_low: assert property (sdaOe |-> sdaOut == 1'b0)
    else $error("data driven high");
  a_stop_starts: assert property ($rose(writeBusy) |-> sStop)
    else $error("write began without stop");
  a_busy_span: assert property ($fell(writeBusy) |-> busyLen_q == WRITE_CYCLES)
    else $error("write time wrong");
  a_busy_cap: assert property (writeBusy |-> busyLen_q < WRITE_CYCLES)
    else $error("write time overrun");
  a_busy_hold: assert property ($rose(writeBusy) |-> writeBusy [*8])
    else $error("busy dropped early");
  a_edge_low: assert property ($changed(sdaOe) |-> !sclClk)
    else $error("data changed with clock high");
  a_drive_held: assert property ($rose(sdaOe) |-> sHeld)
    else $error("drive too short");
  a_drive_ends: assert property (sdaOe |-> ##[1:200] !sdaOe)
    else $error("wire never released");
endmodule : sesa_slave_chk
`default_nettype wire
bind sesa_slave sesa_slave_chk #(.WRITE_CYCLES(WRITE_CYCLES)) uChk (
  .clk(clk), .rstn(rstn), .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .devSel(devSel), .protectPin(protectPin), .writeBusy(writeBusy)
);

//--- tb_top.sv
// Purpose: self-checking bench for the serial memory slave
// Assumes: pulled-up data wire, short internal write time
// Notes: model keeps bytes, latches, lock code and counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sesa_pkg::*;
  localparam int unsigned WC = 400;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] devSel = 3'h0;
  logic protectPin = 1'b0;
  logic sclClk;
  logic sdaLow;
  logic sdaOut;
  logic sdaOe;
  logic writeBusy;
  wire sdaIn = ~(sdaLow | (sdaOe & ~sdaOut));
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int cnt = 0;
  logic [7:0] mem [int];
  logic wl = 1'b0;
  logic rwl = 1'b0;
  logic arm = 1'b0;
  logic [1:0] lk = 2'h0;
  logic [15:0] probe [3] = '{16'h3000, 16'h2000, 16'h0000};
  always #4 clk = ~clk;
  sesa_slave #(.WRITE_CYCLES(WC)) dut (
    .clk(clk), .rstn(rstn), .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .devSel(devSel), .protectPin(protectPin), .writeBusy(writeBusy)
  );
  sesa_master_bfm m (.sclClk(sclClk), .sdaLow(sdaLow), .sdaIn(sdaIn));
  // ****************
  // model and tasks
  // ****************
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  function automatic logic locked(input int a);
    return lk == LOCK_FULL || (lk == LOCK_HALF && a >= int'(LOCK_HALF_BASE))
      || (lk == LOCK_QUARTER && a >= int'(LOCK_QUARTER_BASE));
  endfunction : locked
  task automatic poll();
    logic [7:0] q;
    logic k;
    k = 1'b0;
    for (int i = 0; i < 20 && !k; i++)
    begin
      m.start();
      m.xfer({DEV_TYPE, devSel, 1'b0}, 1'b1, q, k);
      if (i == 0)
        chk("pollBusy", 8'h0, 8'(k));
      m.stop();
    end
    chk("pollDone", 8'h1, 8'(k));
  endtask : poll
  task automatic settle(input logic go);
    m.stop();
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk("busy", 8'(go), 8'(writeBusy));
    if (go)
      poll();
  endtask : settle
  task automatic hdr(input logic [15:0] a);
    logic [7:0] q;
    logic k;
    logic [7:0] b [3];
    b = '{{DEV_TYPE, devSel, 1'b0}, a[15:8], a[7:0]};
    m.start();
    for (int i = 0; i < 3; i++)
    begin
      m.xfer(b[i], 1'b1, q, k);
      chk("ackHdr", 8'h1, 8'(k));
    end
  endtask : hdr
  task automatic wr(input logic [15:0] a, input int n);
    logic [7:0] q;
    logic [7:0] d;
    logic k;
    logic go;
    logic [7:0] stage [int];
    go = wl && !locked(int'(a[13:0]));
    hdr(a);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      m.xfer(d, 1'b1, q, k);
      chk("ackData", 8'(wl), 8'(k));
      stage[{a[13:5], 5'(a[4:0] + i)}] = d;
    end
    if (go)
      foreach (stage[j]) mem[j] = stage[j];
    if (go)
      rwl = 1'b0;
    settle(go);
  endtask : wr
  task automatic regWr(input logic [7:0] v, input logic extra);
    logic [7:0] q;
    logic k;
    logic go;
    go = 1'b0;
    hdr(REG_ADDR);
    m.xfer(v, 1'b1, q, k);
    chk("ackReg", 8'h1, 8'(k));
    if (extra)
    begin
      m.xfer(~v, 1'b1, q, k);
      chk("ackReg2", 8'h0, 8'(k));
    end
    if ((v & PCR_ZERO_MASK) == 8'h00 && rwl && !v[2] && v[1] && !(protectPin && arm))
    begin
      {arm, lk} = {v[7], v[4:3]};
      rwl = 1'b0;
      go = 1'b1;
    end
    else if (!rwl && v == CMD_SET_WLATCH)
      wl = 1'b1;
    else if (!rwl && v == CMD_CLR_WLATCH)
      wl = 1'b0;
    else if (!rwl && wl && v == CMD_SET_RLATCH)
      rwl = 1'b1;
    settle(go);
  endtask : regWr
  task automatic rd(input logic [15:0] a, input int n, input logic cur);
    logic [7:0] q;
    logic [7:0] e;
    logic k;
    if (!cur)
      hdr(a);
    if (!cur)
      cnt = (a == REG_ADDR) ? -1 : int'(a[13:0]);
    m.start();
    m.xfer({DEV_TYPE, devSel, 1'b1}, 1'b1, q, k);
    chk("ackRd", 8'h1, 8'(k));
    for (int i = 0; i < n; i++)
    begin
      e = (cnt < 0) ? {arm, 2'h0, lk, rwl, wl, 1'b0} : mem[cnt];
      m.xfer(8'hff, i == n - 1, q, k);
      chk("rdData", e, q);
      cnt = (cnt + 1) % MEM_BYTES;
    end
    m.stop();
  endtask : rd
  // ****************
  // run
  // ****************
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 95000)
    begin
      n_fail++;
      complete_run();
    end
  end
  initial
  begin
    void'($urandom(97));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    devSel <= 3'($urandom);
    repeat (8) @(posedge clk);
    #3;
    rd(REG_ADDR, 1, 1'b0);
    wr(16'h0100, 1);
    regWr(CMD_SET_WLATCH, 1'b1);
    rd(REG_ADDR, 1, 1'b0);
    $display("test latches done");
    wr(16'h0000, 1);
    wr(16'h3ffe, 34);
    rd(16'h3ffe, 3, 1'b0);
    rd(16'h3fe0, 32, 1'b0);
    rd(16'h0000, 1, 1'b1);
    hdr(16'h3ff0);
    settle(1'b0);
    cnt = 16'h3ff0;
    rd(16'h0000, 2, 1'b1);
    $display("test array done");
    for (int c = 1; c < 4; c++)
    begin
      regWr(CMD_SET_RLATCH, 1'b0);
      regWr({3'h0, 2'(c), 3'h2}, 1'b0);
      foreach (probe[i]) wr(probe[i], 1);
    end
    regWr(8'h1a, 1'b0);
    regWr(CMD_SET_RLATCH, 1'b0);
    regWr(8'h0b, 1'b0);
    regWr(8'h8a, 1'b0);
    rd(REG_ADDR, 1, 1'b0);
    $display("test lock done");
    @(posedge clk);
    protectPin <= 1'b1;
    regWr(CMD_SET_RLATCH, 1'b0);
    regWr(CMD_SET_WLATCH, 1'b0);
    rd(REG_ADDR, 1, 1'b0);
    wr(16'h0010, 1);
    wr(16'h3000, 1);
    rd(16'h0010, 1, 1'b0);
    regWr(CMD_CLR_WLATCH, 1'b0);
    wr(16'h0020, 1);
    $display("test protect done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
